/* File: hw/cdc_exec.v */
// execution unit for watchdog clear, call via accumulator, clear/dec group
`timescale 1ns/1ns
`include "cdc_exec_regs.vh"
module cdc_exec (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        opValid,
  input  wire [2:0]  opCode,
  input  wire [6:0]  fileAddr,
  input  wire        destFile,
  input  wire [7:0]  fileData,
  input  wire [7:0]  accData,
  input  wire [7:0]  pcHighLatch,
  input  wire [14:0] pcIn,
  output reg         opReady,
  output reg         nextDiscard,
  output reg         accWe,
  output reg  [7:0]  accWdata,
  output reg         fileWe,
  output reg  [6:0]  fileWaddr,
  output reg  [7:0]  fileWdata,
  output reg         zeroWe,
  output reg         zeroVal,
  output reg         wdtClear,
  output reg         timeoutFlagNSet,
  output reg         powerdownFlagNSet,
  output reg         stackPush,
  output reg  [14:0] stackData,
  output reg         pcWe,
  output reg  [14:0] pcWdata
);

  localparam ST_RUN  = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [7:0]  result;
  reg        take;
  reg        twoCycle;

  // next values of the registered outputs
  reg        opReady_nxt;
  reg        nextDiscard_nxt;
  reg        accWe_nxt;
  reg [7:0]  accWdata_nxt;
  reg        fileWe_nxt;
  reg [6:0]  fileWaddr_nxt;
  reg [7:0]  fileWdata_nxt;
  reg        zeroWe_nxt;
  reg        zeroVal_nxt;
  reg        wdtClear_nxt;
  reg        timeoutFlagNSet_nxt;
  reg        powerdownFlagNSet_nxt;
  reg        stackPush_nxt;
  reg [14:0] stackData_nxt;
  reg        pcWe_nxt;
  reg [14:0] pcWdata_nxt;

  // shared arithmetic and decoding
  function [7:0] dec8;
    input [7:0] v;
    begin
      dec8 = v - `CDC_ONE8;
    end
  endfunction

  function is_zero8;
    input [7:0] v;
    begin
      is_zero8 = (v == `CDC_ZERO8);
    end
  endfunction

  function [14:0] ret_addr;
    input [14:0] pc;
    begin
      ret_addr = pc + `CDC_ONE15;
    end
  endfunction

  function [14:0] call_target;
    input [7:0] hi;
    input [7:0] lo;
    begin
      call_target = {hi[`CDC_PCH_MSB:0], lo};
    end
  endfunction

  function op_stalls;
    input [2:0] code;
    input [7:0] fdata;
    begin
      op_stalls = (code == `CDC_OP_CALLACC) ||
                  ((code == `CDC_OP_DECSKIP) && is_zero8(dec8(fdata)));
    end
  endfunction

  // data-path result
  always @* begin
    result = `CDC_ZERO8;
    case (opCode)
      `CDC_OP_COMPL:   result = ~fileData;
      `CDC_OP_DEC:     result = dec8(fileData);
      `CDC_OP_DECSKIP: result = dec8(fileData);
      default:         result = `CDC_ZERO8;
    endcase
  end

  // acceptance, wait cycle and completion
  always @* begin
    take      = opValid && (state_r == ST_RUN);
    twoCycle  = take && op_stalls(opCode, fileData);
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (twoCycle) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    opReady_nxt = (take && !twoCycle) || (state_r == ST_WAIT);
    nextDiscard_nxt = take && (opCode == `CDC_OP_DECSKIP) &&
                      is_zero8(result);
  end

  // accumulator write-back
  always @* begin
    accWe_nxt    = 1'h0;
    accWdata_nxt = accWdata;
    if (take) begin
      case (opCode)
        `CDC_OP_COMPL, `CDC_OP_DEC: begin
          accWe_nxt    = !destFile;
          accWdata_nxt = result;
        end
        `CDC_OP_CLRACC: begin
          accWe_nxt    = 1'h1;
          accWdata_nxt = `CDC_ZERO8;
        end
        `CDC_OP_DECSKIP: begin
          accWe_nxt    = !destFile;
          accWdata_nxt = result;
        end
        default: begin
          accWe_nxt    = 1'h0;
        end
      endcase
    end
  end

  // file register write-back
  always @* begin
    fileWe_nxt    = 1'h0;
    fileWaddr_nxt = fileWaddr;
    fileWdata_nxt = fileWdata;
    if (take) begin
      fileWaddr_nxt = fileAddr;
      case (opCode)
        `CDC_OP_COMPL, `CDC_OP_DEC: begin
          fileWe_nxt    = destFile;
          fileWdata_nxt = result;
        end
        `CDC_OP_CLRFILE: begin
          fileWe_nxt    = 1'h1;
          fileWdata_nxt = `CDC_ZERO8;
        end
        `CDC_OP_DECSKIP: begin
          fileWe_nxt    = destFile;
          fileWdata_nxt = result;
        end
        default: begin
          fileWe_nxt    = 1'h0;
        end
      endcase
    end
  end

  // zero flag update; dec-skip leaves flags alone
  always @* begin
    zeroWe_nxt  = 1'h0;
    zeroVal_nxt = zeroVal;
    if (take) begin
      case (opCode)
        `CDC_OP_COMPL, `CDC_OP_DEC: begin
          zeroWe_nxt  = 1'h1;
          zeroVal_nxt = is_zero8(result);
        end
        `CDC_OP_CLRFILE, `CDC_OP_CLRACC: begin
          zeroWe_nxt  = 1'h1;
          zeroVal_nxt = 1'h1;
        end
        default: begin
          zeroWe_nxt  = 1'h0;
        end
      endcase
    end
  end

  // watchdog clear and call via accumulator
  always @* begin
    wdtClear_nxt          = take && (opCode == `CDC_OP_WDTCLR);
    timeoutFlagNSet_nxt   = wdtClear_nxt;
    powerdownFlagNSet_nxt = wdtClear_nxt;
    stackPush_nxt         = take && (opCode == `CDC_OP_CALLACC);
    pcWe_nxt              = stackPush_nxt;
    stackData_nxt         = stackData;
    pcWdata_nxt           = pcWdata;
    if (stackPush_nxt) begin
      stackData_nxt = ret_addr(pcIn);
      pcWdata_nxt   = call_target(pcHighLatch, accData);
    end
  end

  // state register
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // completion and skip pulses
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opReady     <= 1'h0;
      nextDiscard <= 1'h0;
    end else begin
      opReady     <= opReady_nxt;
      nextDiscard <= nextDiscard_nxt;
    end
  end

  // accumulator write port
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accWe    <= 1'h0;
      accWdata <= `CDC_ZERO8;
    end else begin
      accWe    <= accWe_nxt;
      accWdata <= accWdata_nxt;
    end
  end

  // file register write port
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fileWe    <= 1'h0;
      fileWaddr <= `CDC_ZERO7;
      fileWdata <= `CDC_ZERO8;
    end else begin
      fileWe    <= fileWe_nxt;
      fileWaddr <= fileWaddr_nxt;
      fileWdata <= fileWdata_nxt;
    end
  end

  // zero flag write port
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      zeroWe  <= 1'h0;
      zeroVal <= 1'h0;
    end else begin
      zeroWe  <= zeroWe_nxt;
      zeroVal <= zeroVal_nxt;
    end
  end

  // watchdog and status strobes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wdtClear          <= 1'h0;
      timeoutFlagNSet   <= 1'h0;
      powerdownFlagNSet <= 1'h0;
    end else begin
      wdtClear          <= wdtClear_nxt;
      timeoutFlagNSet   <= timeoutFlagNSet_nxt;
      powerdownFlagNSet <= powerdownFlagNSet_nxt;
    end
  end

  // return stack push and program counter load
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stackPush <= 1'h0;
      stackData <= `CDC_ZERO15;
      pcWe      <= 1'h0;
      pcWdata   <= `CDC_ZERO15;
    end else begin
      stackPush <= stackPush_nxt;
      stackData <= stackData_nxt;
      pcWe      <= pcWe_nxt;
      pcWdata   <= pcWdata_nxt;
    end
  end

endmodule

/* File: hw/cdc_exec_regs.vh */
// constants and opcode encodings for the clear/decrement/call execution unit
// Contract
// - watchdog clear loads counter zero and clears its prescaler.
// - watchdog clear sets both active-low timeout and powerdown flags.
// - call via accumulator pushes return address onto stack top first.
// - then pc low byte from accumulator, pc high from high latch bits 6..0.
// - call via accumulator takes two instruction cycles.
// - complement writes inverted file to destination, updates zero flag.
// - clear file writes zero to addressed register and sets zero flag.
// - clear accumulator writes zero to accumulator and sets zero flag.
// - decrement writes file minus one to chosen destination, updates zero.
// - decrement-skip writes file minus one to destination, flags unchanged.
// - nonzero decrement-skip result lets next instruction run normally.
// - zero result discards next instruction, runs no-op, two cycles.
`ifndef CDC_EXEC_REGS_VH
`define CDC_EXEC_REGS_VH
`define CDC_OP_NONE      3'h0
`define CDC_OP_WDTCLR    3'h1
`define CDC_OP_CALLACC   3'h2
`define CDC_OP_COMPL     3'h3
`define CDC_OP_CLRFILE   3'h4
`define CDC_OP_CLRACC    3'h5
`define CDC_OP_DEC       3'h6
`define CDC_OP_DECSKIP   3'h7
`define CDC_ZERO8        8'h00
`define CDC_ONE8         8'h01
`define CDC_ZERO15       15'h0000
`define CDC_ONE15        15'h0001
`define CDC_ZERO7        7'h00
`define CDC_PCH_MSB      6
`endif

/* File: testbench/cdc_exec_checker.sv */
// port assertions for the execution unit
`timescale 1ns/1ns
module cdc_exec_checker (
  input logic        clk_sys,
  input logic        arst_n,
  input logic        opValid,
  input logic [2:0]  opCode,
  input logic [7:0]  fileData,
  input logic [7:0]  accData,
  input logic [7:0]  pcHighLatch,
  input logic [14:0] pcIn,
  input logic        opReady,
  input logic        nextDiscard,
  input logic        zeroWe,
  input logic        wdtClear,
  input logic        stackPush,
  input logic [14:0] stackData,
  input logic        pcWe,
  input logic [14:0] pcWdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire tk = opValid && !pcWe && !nextDiscard;
  wire sk = tk && opCode == 3'h7;
  a_wdt_clear: assert property (
    $past(tk && opCode == 3'h1) |-> wdtClear) else $error("no clear");
  a_wdt_cause: assert property (
    wdtClear |-> $past(tk && opCode == 3'h1)) else $error("stray clear");
  a_call_push: assert property (
    stackPush |-> pcWe && stackData == $past(pcIn) + 15'h1 &&
      pcWdata == {$past(pcHighLatch[6:0]), $past(accData)})
    else $error("bad push");
  a_call_two: assert property (
    stackPush |-> !opReady ##1 opReady) else $error("call length");
  a_skip_flags: assert property (
    $past(sk) |-> !zeroWe) else $error("skip flag write");
  a_skip_zero: assert property (
    $past(sk && fileData == 8'h01) |-> nextDiscard ##1 opReady)
    else $error("no skip");
  a_skip_go: assert property (
    $past(sk && fileData != 8'h01) |-> opReady && !nextDiscard)
    else $error("bad skip");
  a_one_cycle: assert property (
    $past(tk && opCode > 3'h2 && opCode < 3'h7) |-> opReady)
    else $error("slow op");
  cover property (stackPush);
  cover property (nextDiscard);
  cover property (wdtClear);
endmodule
bind cdc_exec cdc_exec_checker chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
  .fileData(fileData), .accData(accData), .pcHighLatch(pcHighLatch),
  .pcIn(pcIn), .opReady(opReady), .nextDiscard(nextDiscard),
  .zeroWe(zeroWe), .wdtClear(wdtClear), .stackPush(stackPush),
  .stackData(stackData), .pcWe(pcWe), .pcWdata(pcWdata));

/* File: testbench/cdc_exec_tb.sv */
// self-checking bench for the execution unit
`timescale 1ns/1ns
module cdc_exec_tb;
  logic        clk_sys = 1'b0, arst_n = 1'b0, opValid = 1'b0, destFile = 1'b0;
  logic [2:0]  opCode = 3'h0;
  logic [6:0]  fileAddr = 7'h7f, fileWaddr;
  logic [7:0]  fileData = 8'h00, accData = 8'ha5, pcHighLatch = 8'hd3;
  logic [7:0]  accWdata, fileWdata;
  logic [14:0] pcIn = 15'h7fff, stackData, pcWdata;
  logic        opReady, nextDiscard, accWe, fileWe, zeroWe, zeroVal, wdtClear;
  logic        timeoutFlagNSet, powerdownFlagNSet, stackPush, pcWe;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  cdc_exec DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
    .fileAddr(fileAddr), .destFile(destFile), .fileData(fileData),
    .accData(accData), .pcHighLatch(pcHighLatch), .pcIn(pcIn),
    .opReady(opReady), .nextDiscard(nextDiscard), .accWe(accWe),
    .accWdata(accWdata), .fileWe(fileWe), .fileWaddr(fileWaddr),
    .fileWdata(fileWdata), .zeroWe(zeroWe), .zeroVal(zeroVal),
    .wdtClear(wdtClear), .timeoutFlagNSet(timeoutFlagNSet),
    .powerdownFlagNSet(powerdownFlagNSet), .stackPush(stackPush),
    .stackData(stackData), .pcWe(pcWe), .pcWdata(pcWdata));
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic d, input logic [7:0] f);
    @(posedge clk_sys);
    opCode <= c;
    destFile <= d;
    fileData <= f;
    opValid <= 1'b1;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
  endtask
  task automatic t_call;
    op(3'h1, 1'b0, 8'h00);
    chk({wdtClear, timeoutFlagNSet, powerdownFlagNSet}, 3'h7);
    op(3'h2, 1'b0, 8'h00);
    chk(pcWdata, 15'h53a5);
    chk(stackData, 15'h0000);
    chk(opReady, 1'b0);
    @(posedge clk_sys);
    #1;
    chk(opReady, 1'b1);
  endtask
  task automatic t_clear;
    op(3'h0, 1'b0, 8'h00);
    chk({opReady, accWe, fileWe, zeroWe}, 4'h8);
    op(3'h3, 1'b1, 8'h0f);
    chk({fileWe, zeroVal, fileWdata}, 10'h2f0);
    op(3'h4, 1'b0, 8'h5a);
    chk({zeroVal, fileWaddr, fileWdata}, 16'hff00);
    op(3'h5, 1'b1, 8'h5a);
    chk({accWe, zeroVal, accWdata}, 10'h300);
    op(3'h6, 1'b0, 8'h01);
    chk({accWe, zeroVal, accWdata}, 10'h300);
  endtask
  task automatic t_skip;
    op(3'h7, 1'b1, 8'h02);
    chk({nextDiscard, fileWdata}, 9'h001);
    op(3'h7, 1'b0, 8'h01);
    chk({nextDiscard, zeroWe, accWdata}, 10'h200);
    @(posedge clk_sys);
    #1;
    chk(opReady, 1'b1);
  endtask
  task automatic complete_run;
    $display("tests %0d, fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_call;
    t_clear;
    t_skip;
    complete_run;
  end
endmodule
